// ==== core/pclk_ctrl.sv ====
// PLL control register, divider source switch and divider change sequencer
`timescale 1ns/1ps
// Contract
// [R1] 32-bit PLL control, word access, fixed reset
// [R2] Feedback divide equals field plus two
// [R3] Input divide equals field plus two
// [R4] Output divide codes 1,2,2,4
// [R5] Output frequency is input times M/N/NO
// [R6] Stable flag reads one once locked
// [R7] Enable starts lock, then source to PLL
// [R8] Disable selects 12 MHz input regardless
// [R9] Bypass selects 12 MHz while PLL runs
// [R10] Stabilise time counts RTC ticks, resets 11h
// [R11] Bits 15:11 ignore writes, read zero
// [R12] Software keeps raw frequency at least 100MHz
// [R13] Software keeps main divider ratios legal
// [R14] Change enable starts main division sequence
// [R15] Software gates device around peripheral change
// [R16] Peripheral divider applied now or at relock
// [R17] Source switch without truncated clock pulses
module pclk_ctrl
  import pclk_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic real_time_clock_tick_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic synth_enable_o,
  output logic [9:0] feedback_divide_o,
  output logic [5:0] input_divide_o,
  output logic [2:0] output_divide_o,
  output logic src_pll_sel_o,
  output logic div_hold_o,
  output logic [15:0] main_dividers_o,
  output logic [8:0] audio_serial_divider_o,
  output logic [10:0] pixel_clock_divider_o,
  output logic irq_o
);

  // Reset release through two flops
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // RTC tick pin: three flops, edge counts once stages two and three agree
  logic [2:0] rtc_sync_q;
  logic rtc_level_q;
  logic rtc_edge;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rtc_sync_q <= 3'b000;
      rtc_level_q <= 1'b0;
    end else begin
      rtc_sync_q <= {rtc_sync_q[1:0], real_time_clock_tick_i};
      if (rtc_sync_q[1] == rtc_sync_q[2]) begin
        rtc_level_q <= rtc_sync_q[2];
      end
    end
  end
  assign rtc_edge = (rtc_sync_q[1] == rtc_sync_q[2]) && rtc_sync_q[2] && !rtc_level_q;

  // AXI4-Lite write channel capture, address and data in either order
  logic aw_held_q, w_held_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire, wr_ok, wr_full;
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_full = (w_strb_q == 4'hF);
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PCLK_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? PCLK_RESP_OKAY : PCLK_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Partial-word or unmapped writes store nothing
  logic wr_pll, wr_main, wr_periph, wr_sts, wr_mask;
  assign wr_pll = wr_fire && wr_full && (aw_addr_q == PCLK_OFF_PLL_CTL); // see [R1]
  assign wr_main = wr_fire && wr_full && (aw_addr_q == PCLK_OFF_MAIN_CTL);
  assign wr_periph = wr_fire && wr_full && (aw_addr_q == PCLK_OFF_PERIPH);
  assign wr_sts = wr_fire && wr_full && (aw_addr_q == PCLK_OFF_IRQ_STS);
  assign wr_mask = wr_fire && wr_full && (aw_addr_q == PCLK_OFF_IRQ_MASK);
  assign wr_ok = wr_pll || wr_main || wr_periph || wr_sts || wr_mask;

  // PLL control register; reserved bits and lock flag never stored
  logic [31:0] ctl_q, ctl_new;
  logic relock;
  assign ctl_new = w_data_q & PCLK_PLL_CTL_WMASK; // see [R11]
  // Relock on turn-on or a change to the M, N or NO fields while running
  assign relock = wr_pll && ctl_new[PCLK_EN_BIT] && (!ctl_q[PCLK_EN_BIT] ||
      (ctl_new[PCLK_FB_HI:PCLK_OD_LO] != ctl_q[PCLK_FB_HI:PCLK_OD_LO])); // see [R7]
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= PCLK_PLL_CTL_RST & PCLK_PLL_CTL_WMASK; // see [R1]
    end else if (wr_pll) begin
      ctl_q <= ctl_new;
    end
  end

  // Divide values handed to the analog PLL
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      synth_enable_o <= 1'b0;
      feedback_divide_o <= 10'h000;
      input_divide_o <= 6'h00;
      output_divide_o <= 3'h1;
    end else begin
      synth_enable_o <= ctl_q[PCLK_EN_BIT]; // see [R8]
      feedback_divide_o <= {1'b0, ctl_q[PCLK_FB_HI:PCLK_FB_LO]} + PCLK_DIV_OFFSET; // see [R2]
      input_divide_o <= {1'b0, ctl_q[PCLK_IN_HI:PCLK_IN_LO]} + PCLK_DIV_OFFSET[5:0]; // see [R3]
      // Codes 01 and 10 both give two; NO = 2^(od0+od1), see [R4] [R5]
      unique case (ctl_q[PCLK_OD_HI:PCLK_OD_LO])
        2'b00: output_divide_o <= 3'h1;
        2'b01: output_divide_o <= 3'h2;
        2'b10: output_divide_o <= 3'h2;
        2'b11: output_divide_o <= 3'h4;
      endcase
    end
  end

  // Stabilise counter on RTC ticks; lock flag drops with enable
  logic [7:0] stab_cnt_q;
  logic stab_run_q, lock_q;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      stab_cnt_q <= 8'h00;
      stab_run_q <= 1'b0;
      lock_q <= 1'b0;
    end else if (relock) begin
      stab_cnt_q <= ctl_new[PCLK_ST_HI:0]; // see [R10]
      stab_run_q <= 1'b1;
      lock_q <= 1'b0;
    end else if (!ctl_q[PCLK_EN_BIT]) begin
      stab_run_q <= 1'b0; // see [R8]
      lock_q <= 1'b0; // see [R6]
    end else if (stab_run_q && rtc_edge) begin
      if (stab_cnt_q == 8'h00) begin
        stab_run_q <= 1'b0;
        lock_q <= 1'b1; // see [R6] [R7]
      end else begin
        stab_cnt_q <= stab_cnt_q - 8'h01; // see [R10]
      end
    end
  end

  // Desired divider source: PLL only when on, locked and not bypassed
  logic want_pll;
  assign want_pll = ctl_q[PCLK_EN_BIT] && lock_q && !ctl_q[PCLK_BYP_BIT]; // see [R7] [R8] [R9]

  // Main clock control and pending peripheral dividers
  logic [31:0] main_ctl_q, periph_q;
  logic main_start, div_req_q, periph_pend_q;
  assign main_start = wr_main && main_ctl_q[PCLK_CE_BIT] &&
      (w_data_q[PCLK_MAIN_DIV_W-1:0] != main_dividers_o);
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      main_ctl_q <= PCLK_MAIN_CTL_RST;
      periph_q <= PCLK_PERIPH_RST;
    end else begin
      if (wr_main) begin
        main_ctl_q <= w_data_q & PCLK_MAIN_CTL_WMASK;
      end
      if (wr_periph) begin
        periph_q <= w_data_q & PCLK_PERIPH_WMASK;
      end
    end
  end

  // Peripheral dividers: now with change enable, else at the next relock
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      audio_serial_divider_o <= PCLK_PERIPH_RST[8:0];
      pixel_clock_divider_o <= PCLK_PERIPH_RST[26:16];
      periph_pend_q <= 1'b0;
    end else if (wr_periph && main_ctl_q[PCLK_CE_BIT]) begin
      audio_serial_divider_o <= w_data_q[8:0]; // see [R16]
      pixel_clock_divider_o <= w_data_q[26:16];
      periph_pend_q <= 1'b0;
    end else if (wr_periph) begin
      periph_pend_q <= 1'b1; // see [R16]
    end else if (relock && periph_pend_q) begin
      audio_serial_divider_o <= periph_q[8:0]; // see [R16]
      pixel_clock_divider_o <= periph_q[26:16];
      periph_pend_q <= 1'b0;
    end
  end

  // Sequencer: hold dividers, swap source or ratios, release
  pclk_seq_e seq_q;
  logic [3:0] gate_cnt_q;
  logic seq_need;
  assign seq_need = div_req_q || (want_pll != src_pll_sel_o);
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      seq_q <= PCLK_SEQ_IDLE;
      gate_cnt_q <= 4'h0;
    end else begin
      unique case (seq_q)
        PCLK_SEQ_IDLE: begin
          if (seq_need) begin
            seq_q <= PCLK_SEQ_GATE;
            gate_cnt_q <= PCLK_GATE_CYC;
          end
        end
        PCLK_SEQ_GATE: begin
          // Let outstanding divided pulses finish before swapping
          if (gate_cnt_q == 4'h0) begin
            seq_q <= PCLK_SEQ_SWAP; // see [R17]
          end else begin
            gate_cnt_q <= gate_cnt_q - 4'h1;
          end
        end
        PCLK_SEQ_SWAP: begin
          seq_q <= PCLK_SEQ_UNGATE;
          gate_cnt_q <= PCLK_GATE_CYC;
        end
        PCLK_SEQ_UNGATE: begin
          if (gate_cnt_q == 4'h0) begin
            seq_q <= PCLK_SEQ_IDLE;
          end else begin
            gate_cnt_q <= gate_cnt_q - 4'h1;
          end
        end
      endcase
    end
  end

  // Hold line and swapped values, all from flops
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      div_hold_o <= 1'b0;
      src_pll_sel_o <= 1'b0;
      main_dividers_o <= PCLK_MAIN_CTL_RST[15:0];
      div_req_q <= 1'b0;
    end else begin
      div_hold_o <= (seq_q == PCLK_SEQ_IDLE) ? seq_need : !(seq_q == PCLK_SEQ_UNGATE &&
          gate_cnt_q == 4'h0); // see [R17]
      if (seq_q == PCLK_SEQ_SWAP) begin
        src_pll_sel_o <= want_pll; // see [R7] [R9]
        if (div_req_q) begin
          main_dividers_o <= main_ctl_q[PCLK_MAIN_DIV_W-1:0]; // see [R14]
        end
      end
      // Only a write made while change enable is already set starts the division sequence
      if (main_start) begin
        div_req_q <= 1'b1; // see [R14]
      end else if (seq_q == PCLK_SEQ_SWAP) begin
        div_req_q <= 1'b0;
      end
    end
  end

  // Sticky status, set wins over write-one-to-clear
  logic [PCLK_IRQ_W-1:0] sts_q, mask_q, ev;
  logic lock_d1_q;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      lock_d1_q <= 1'b0;
    end else begin
      lock_d1_q <= lock_q;
    end
  end
  assign ev[PCLK_IRQ_LOCK] = lock_q && !lock_d1_q;
  assign ev[PCLK_IRQ_DIV] = (seq_q == PCLK_SEQ_SWAP) && div_req_q;
  assign ev[PCLK_IRQ_SRC] = (seq_q == PCLK_SEQ_SWAP) && (want_pll != src_pll_sel_o);
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      sts_q <= '0;
      mask_q <= '0;
      irq_o <= 1'b0;
    end else begin
      sts_q <= (sts_q & ~(wr_sts ? w_data_q[PCLK_IRQ_W-1:0] : '0)) | ev;
      if (wr_mask) begin
        mask_q <= w_data_q[PCLK_IRQ_W-1:0];
      end
      irq_o <= |(sts_q & mask_q);
    end
  end

  // Read channel; one cycle from address to data
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      PCLK_OFF_PLL_CTL: rd_mux = ctl_q | ({31'h0, lock_q} << PCLK_LOCK_BIT); // see [R6]
      PCLK_OFF_MAIN_CTL: rd_mux = main_ctl_q;
      PCLK_OFF_PERIPH: rd_mux = periph_q;
      PCLK_OFF_IRQ_STS: rd_mux = {29'h0, sts_q};
      PCLK_OFF_IRQ_MASK: rd_mux = {29'h0, mask_q};
      PCLK_OFF_STATE: rd_mux = {26'h0, seq_q, periph_pend_q, div_req_q, div_hold_o,
          src_pll_sel_o};
      default: rd_hit = 1'b0;
    endcase
  end
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= PCLK_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? PCLK_RESP_OKAY : PCLK_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  localparam int SEQ_MAX = 20;
  chk_partial_write: assert property (@(posedge clock_i) disable iff (!rst_n) // see [R1]
    (wr_fire && !wr_full) |=> (s_axi_bresp == PCLK_RESP_SLVERR) && $stable(ctl_q))
    else $error("partial write not refused");
  // Gated on the previous cycle being out of reset, so the first edge after release is skipped
  chk_feedback_value: assert property (@(posedge clock_i) disable iff (!rst_n) // see [R2]
    $past(rst_n) |-> feedback_divide_o == {1'b0, $past(ctl_q[PCLK_FB_HI:PCLK_FB_LO])} + 10'h002)
    else $error("feedback divide wrong");
  chk_input_value: assert property (@(posedge clock_i) disable iff (!rst_n) // see [R3]
    $past(rst_n) |-> input_divide_o == {1'b0, $past(ctl_q[PCLK_IN_HI:PCLK_IN_LO])} + 6'h02)
    else $error("input divide wrong");
  chk_output_code: assert property (@(posedge clock_i) disable iff (!rst_n) // see [R4]
    ($past(ctl_q[PCLK_OD_HI:PCLK_OD_LO]) == 2'b11) |-> output_divide_o == 3'h4)
    else $error("output divide wrong");
  chk_lock_drops: assert property (@(posedge clock_i) disable iff (!rst_n) // see [R6]
    $fell(ctl_q[PCLK_EN_BIT]) |=> !lock_q)
    else $error("lock flag kept with pll off");
  chk_src_needs_lock: assert property (@(posedge clock_i) disable iff (!rst_n) // see [R7]
    $rose(src_pll_sel_o) |-> $past(lock_q && ctl_q[PCLK_EN_BIT] && !ctl_q[PCLK_BYP_BIT]))
    else $error("pll source picked without lock");
  chk_off_to_input: assert property (@(posedge clock_i) disable iff (!rst_n) // see [R8]
    (!ctl_q[PCLK_EN_BIT] && src_pll_sel_o) |-> ##[1:SEQ_MAX] !src_pll_sel_o)
    else $error("source stays on pll after disable");
  chk_bypass_input: assert property (@(posedge clock_i) disable iff (!rst_n) // see [R9]
    (ctl_q[PCLK_BYP_BIT] && src_pll_sel_o) |-> ##[1:SEQ_MAX] !src_pll_sel_o)
    else $error("bypass ignored");
  chk_reserved_zero: assert property (@(posedge clock_i) disable iff (!rst_n) // see [R11]
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == PCLK_OFF_PLL_CTL)
      |=> s_axi_rdata[15:11] == 5'h00)
    else $error("reserved bits not zero");
  chk_div_done: assert property (@(posedge clock_i) disable iff (!rst_n) // see [R14]
    div_req_q |-> ##[1:SEQ_MAX] !div_req_q)
    else $error("division sequence stuck");
  chk_div_only_swap: assert property (@(posedge clock_i) disable iff (!rst_n) // see [R14]
    $changed(main_dividers_o) |-> $past(seq_q == PCLK_SEQ_SWAP && div_req_q))
    else $error("dividers changed outside sequence");
  chk_switch_held: assert property (@(posedge clock_i) disable iff (!rst_n) // see [R17]
    $changed(src_pll_sel_o) |-> div_hold_o && $past(div_hold_o, 2))
    else $error("source switched while dividers running");
  chk_irq_level: assert property (@(posedge clock_i) disable iff (!rst_n)
    $past(rst_n) |-> irq_o == |($past(sts_q) & $past(mask_q)))
    else $error("interrupt output wrong");
  cov_lock: cover property (@(posedge clock_i) disable iff (!rst_n) $rose(lock_q));
  cov_to_pll: cover property (@(posedge clock_i) disable iff (!rst_n) $rose(src_pll_sel_o));
  cov_div_seq: cover property (@(posedge clock_i) disable iff (!rst_n) ev[PCLK_IRQ_DIV]);
  cov_periph_late: cover property (@(posedge clock_i) disable iff (!rst_n)
    relock && periph_pend_q);

endmodule

// ==== core/pclk_pkg.sv ====
// Constants for the PLL and clock divider control block
package pclk_pkg;
  // Register byte offsets
  localparam logic [7:0] PCLK_OFF_PLL_CTL = 8'h00;
  localparam logic [7:0] PCLK_OFF_MAIN_CTL = 8'h04;
  localparam logic [7:0] PCLK_OFF_PERIPH = 8'h08;
  localparam logic [7:0] PCLK_OFF_IRQ_STS = 8'h0C;
  localparam logic [7:0] PCLK_OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] PCLK_OFF_STATE = 8'h14;
  // Reset values
  localparam logic [31:0] PCLK_PLL_CTL_RST = 32'h28080011;
  localparam logic [31:0] PCLK_MAIN_CTL_RST = 32'h00000000;
  localparam logic [31:0] PCLK_PERIPH_RST = 32'h00040004;
  // PLL control fields
  localparam int PCLK_FB_HI = 31;
  localparam int PCLK_FB_LO = 23;
  localparam int PCLK_IN_HI = 22;
  localparam int PCLK_IN_LO = 18;
  localparam int PCLK_OD_HI = 17;
  localparam int PCLK_OD_LO = 16;
  localparam int PCLK_LOCK_BIT = 10;
  localparam int PCLK_BYP_BIT = 9;
  localparam int PCLK_EN_BIT = 8;
  localparam int PCLK_ST_HI = 7;
  localparam logic [31:0] PCLK_PLL_CTL_WMASK = 32'hFFFF03FF;
  localparam logic [9:0] PCLK_DIV_OFFSET = 10'h002;
  // Main clock control: four 4-bit divider fields and change enable
  localparam int PCLK_MAIN_DIV_W = 16;
  localparam int PCLK_CE_BIT = 22;
  localparam logic [31:0] PCLK_MAIN_CTL_WMASK = 32'h0040FFFF;
  // Peripheral dividers: audio [8:0], pixel [26:16]
  localparam logic [31:0] PCLK_PERIPH_WMASK = 32'h07FF01FF;
  // Interrupt status bits
  localparam int PCLK_IRQ_W = 3;
  localparam int PCLK_IRQ_LOCK = 0;
  localparam int PCLK_IRQ_DIV = 1;
  localparam int PCLK_IRQ_SRC = 2;
  // Cycles the dividers stay held around a swap
  localparam logic [3:0] PCLK_GATE_CYC = 4'h4;
  // AXI responses
  localparam logic [1:0] PCLK_RESP_OKAY = 2'h0;
  localparam logic [1:0] PCLK_RESP_SLVERR = 2'h2;
  // Sequencer states
  typedef enum logic [1:0] {
    PCLK_SEQ_IDLE = 2'b00,
    PCLK_SEQ_GATE = 2'b01,
    PCLK_SEQ_SWAP = 2'b10,
    PCLK_SEQ_UNGATE = 2'b11
  } pclk_seq_e;
endpackage

// ==== test/tb_top.sv ====
// Self-checking testbench for the PLL and clock divider control block
`timescale 1ns/1ps
module tb_top
  import pclk_pkg::*;
;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic rtc_tick = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic synth_enable, src_pll_sel, div_hold, irq;
  logic [9:0] fb_div;
  logic [5:0] in_div;
  logic [2:0] out_div;
  logic [15:0] main_div;
  logic [8:0] audio_div;
  logic [10:0] pixel_div;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [1:0] resp;

  pclk_ctrl dut (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .real_time_clock_tick_i(rtc_tick),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .synth_enable_o(synth_enable),
    .feedback_divide_o(fb_div), .input_divide_o(in_div), .output_divide_o(out_div),
    .src_pll_sel_o(src_pll_sel), .div_hold_o(div_hold), .main_dividers_o(main_div),
    .audio_serial_divider_o(audio_div), .pixel_clock_divider_o(pixel_div), .irq_o(irq)
  );

  // 100 MHz clock
  initial begin
    forever #5 clock_i = ~clock_i;
  end

  // Verdict and end of run, reached from the main sequence or the timeout
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("[FAIL] run time expected below 20000 seen %0d", cycles);
      end_sim();
    end
  end

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s response expected %h seen %h", what, exp, got);
    end
  endtask

  // Let n edges pass, then step off the edge so outputs have settled
  task automatic settle(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // Write address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clock_i);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clock_i);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge clock_i);
    while (s_axi_arready !== 1'b1) @(posedge clock_i);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clock_i);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, 4'hF, resp);
    chk_resp("write", PCLK_RESP_OKAY, resp);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk_val(what, exp, d);
    chk_resp(what, PCLK_RESP_OKAY, r);
  endtask

  // One slow clock tick, several fast cycles high and low for the synchroniser
  task automatic rtc_pulse();
    @(posedge clock_i);
    rtc_tick <= 1'b1;
    repeat (4) @(posedge clock_i);
    rtc_tick <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask

  // Main sequence; the switch sequence takes about a dozen cycles, 20 are allowed
  initial begin
    logic [31:0] d;
    repeat (20) @(posedge clock_i);
    reset_n_i <= 1'b1;
    settle(4);
    rd_chk("pll reset", PCLK_OFF_PLL_CTL, 32'h28080011);
    chk_val("m reset", 32'd82, fb_div);
    chk_val("n reset", 32'd4, in_div);
    chk_val("no reset", 32'd1, out_div);
    $display("test reset done");
    // Partial write and unmapped read are refused
    axi_wr(PCLK_OFF_PLL_CTL, 32'h00000000, 4'h3, resp);
    chk_resp("partial write", PCLK_RESP_SLVERR, resp);
    rd_chk("after partial", PCLK_OFF_PLL_CTL, 32'h28080011);
    axi_rd(8'h40, d, resp);
    chk_resp("unmapped read", PCLK_RESP_SLVERR, resp);
    $display("test access done");
    // Extreme fields, reserved and flag bits set, bypass while off
    wr(PCLK_OFF_PLL_CTL, 32'hFFFFFE00);
    settle(20);
    rd_chk("reserved zero", PCLK_OFF_PLL_CTL, 32'hFFFF0200);
    chk_val("m max", 32'd513, fb_div);
    chk_val("n max", 32'd33, in_div);
    chk_val("bypass off", 32'd0, src_pll_sel);
    for (int c = 0; c < 4; c++) begin
      wr(PCLK_OFF_PLL_CTL, 32'(c) << 16);
      settle(2);
      chk_val("no code", (c == 0) ? 32'd1 : (c == 3) ? 32'd4 : 32'd2, out_div);
    end
    chk_val("m min", 32'd2, fb_div);
    chk_val("n min", 32'd2, in_div);
    $display("test fields done");
    // Enable with stabilise time 2: lock after three ticks, then PLL source; raw 246 MHz
    wr(PCLK_OFF_PLL_CTL, 32'h28080102);
    rtc_pulse();
    rtc_pulse();
    rd_chk("not yet stable", PCLK_OFF_PLL_CTL, 32'h28080102);
    chk_val("enable out", 32'd1, synth_enable);
    rtc_pulse();
    settle(20);
    rd_chk("stable", PCLK_OFF_PLL_CTL, 32'h28080502);
    chk_val("src pll", 32'd1, src_pll_sel);
    chk_val("no hold", 32'd0, div_hold);
    rd_chk("state idle", PCLK_OFF_STATE, 32'h00000001);
    rd_chk("status", PCLK_OFF_IRQ_STS, 32'h00000005);
    chk_val("irq masked", 32'd0, irq);
    wr(PCLK_OFF_IRQ_MASK, 32'h00000001);
    settle(3);
    chk_val("irq raised", 32'd1, irq);
    wr(PCLK_OFF_IRQ_STS, 32'h00000001);
    settle(3);
    chk_val("irq cleared", 32'd0, irq);
    rd_chk("status after clear", PCLK_OFF_IRQ_STS, 32'h00000004);
    $display("test lock done");
    // Bypass while running keeps the lock, then returns to PLL
    wr(PCLK_OFF_PLL_CTL, 32'h28080302);
    settle(20);
    chk_val("bypass src", 32'd0, src_pll_sel);
    rd_chk("bypass stable", PCLK_OFF_PLL_CTL, 32'h28080702);
    wr(PCLK_OFF_PLL_CTL, 32'h28080102);
    settle(20);
    chk_val("unbypass src", 32'd1, src_pll_sel);
    $display("test bypass done");
    // Main dividers: stored only until change enable is already set; ratios core 1, bus 2,
    // memory 2, peripheral 4 keep the legal relations
    wr(PCLK_OFF_MAIN_CTL, 32'h00001111);
    settle(20);
    chk_val("main held", 32'd0, main_div);
    rd_chk("main stored", PCLK_OFF_MAIN_CTL, 32'h00001111);
    wr(PCLK_OFF_MAIN_CTL, 32'h00401111);
    settle(20);
    chk_val("main ce set", 32'd0, main_div);
    wr(PCLK_OFF_MAIN_CTL, 32'h00401310);
    settle(20);
    chk_val("main applied", 32'h1310, main_div);
    rd_chk("status div", PCLK_OFF_IRQ_STS, 32'h00000006);
    $display("test main done");
    // Peripheral dividers: device clocks taken as gated around each write
    wr(PCLK_OFF_PERIPH, 32'h07FF01FF);
    settle(1);
    chk_val("audio now", 32'h1FF, audio_div);
    chk_val("pixel now", 32'h7FF, pixel_div);
    wr(PCLK_OFF_MAIN_CTL, 32'h00001310);
    wr(PCLK_OFF_PERIPH, 32'h00100010);
    settle(20);
    chk_val("audio pending", 32'h1FF, audio_div);
    wr(PCLK_OFF_PLL_CTL, 32'h30080102);
    settle(20);
    chk_val("audio relock", 32'h010, audio_div);
    chk_val("pixel relock", 32'h010, pixel_div);
    chk_val("m relock", 32'd98, fb_div);
    rtc_pulse();
    rtc_pulse();
    rtc_pulse();
    settle(20);
    chk_val("relocked src", 32'd1, src_pll_sel);
    $display("test periph done");
    // Disable from the PLL source drops the lock and selects the input clock
    wr(PCLK_OFF_PLL_CTL, 32'h30080202);
    settle(20);
    rd_chk("disabled", PCLK_OFF_PLL_CTL, 32'h30080202);
    chk_val("disabled src", 32'd0, src_pll_sel);
    chk_val("disabled out", 32'd0, synth_enable);
    $display("test disable done");
    end_sim();
  end
endmodule
